// ===== logic/pfx_fragment_ctl.sv
/*
 * holds the per-pixel fragment test and write control with its apb register file.
 * assumes one 200 mhz clock, fragments from the same clock domain, one per cycle.
 */
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "pfx_params.svh"
module pfx_fragment_ctl import pfx_pkg::*; (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // pixel path
  input  wire pfx_frag_t   frag_in,
  output pfx_wr_t          wr_out,
  output logic             wr_valid
);
  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [`PFX_CTRL_W-1:0] ctrl;
    logic [31:0]            zacol;
    logic [31:0]            cliph;
    logic [31:0]            clipv;
    logic [23:0]            key;
    logic [31:0]            stip;
    logic [31:0]            failcnt;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    pfx_wr_t                wr;
    logic                   wr_valid;
  } pfx_state_t;

  pfx_state_t st_r;
  pfx_state_t st_nxt;

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  // ordered dither threshold, 4x4 or 2x2, range 0..15
  function automatic logic [3:0] dith_val(input logic two, input logic [9:0] x, input logic [9:0] y);
    logic [63:0] m4;
    logic [15:0] m2;
    m4 = 64'h5d7f_91b3_c4e6_08a2;
    m2 = 16'h4c08;
    if (two) dith_val = m2[{y[0], x[0], 2'h0} +: 4];
    else dith_val = m4[{y[1:0], x[1:0], 2'h0} +: 4];
  endfunction
  // reduce one 8-bit channel to n bits, with optional dither
  function automatic logic [7:0] chan_red(input logic [7:0] c, input logic [3:0] d, input logic en,
                                          input logic six);
    logic [8:0] s;
    s = six ? ({1'b0, c} + {7'h00, d[3:2]}) : ({1'b0, c} + {5'h00, d[3:1]});
    if (!en) chan_red = c;
    else if (s[8]) chan_red = 8'hff;
    else chan_red = s[7:0];
  endfunction
  // subtract dither from a 565 destination colour, clamped at zero
  function automatic logic [15:0] dsub565(input logic [15:0] p, input logic [3:0] d);
    logic [4:0] r;
    logic [5:0] g;
    logic [4:0] b;
    r = (p[15:11] > {4'h0, d[3]}) ? 5'(p[15:11] - {4'h0, d[3]}) : 5'h00;
    g = (p[10:5]  > {5'h00, d[3]}) ? 6'(p[10:5] - {5'h00, d[3]}) : 6'h00;
    b = (p[4:0]   > {4'h0, d[3]}) ? 5'(p[4:0] - {4'h0, d[3]}) : 5'h00;
    dsub565 = {r, g, b};
  endfunction

  // --------------------------------------------------------------------------
  // depth unit
  // --------------------------------------------------------------------------
  logic        depth_pass;
  logic [15:0] depth_store;

  pfx_depth_cmp u_depth (
    .w_sel       (st_r.ctrl[`PFX_B_WSEL]),
    .bias_en     (st_r.ctrl[`PFX_B_BIAS]),
    .const_en    (st_r.ctrl[`PFX_B_CONSTZ]),
    .func        (pfx_func_t'(st_r.ctrl[`PFX_B_FUNC_HI:`PFX_B_FUNC_LO])),
    .const_depth (st_r.zacol[15:0]),
    .z_iter      (frag_in.z_iter),
    .w_inv       (frag_in.w_inv),
    .dst_depth   (frag_in.dst_depth),
    .pass        (depth_pass),
    .store_depth (depth_store)
  );

  // --------------------------------------------------------------------------
  // combinational next state
  // --------------------------------------------------------------------------
  logic        apb_acc;
  logic        clip_ok;
  logic        key_hit;
  logic [7:0]  stip_row;
  logic        stip_bit;
  logic        stip_ok;
  logic        amask_ok;
  logic        depth_ok;
  logic        alive;
  logic [3:0]  dv;
  logic [9:0]  ry;
  logic [7:0]  red_d;
  logic [7:0]  grn_d;
  logic [7:0]  blu_d;

  always_comb begin
    st_nxt = st_r;
    apb_acc = psel && penable;
    // clip rectangle, bounds inclusive: hi half is max, lo half is min
    clip_ok = !st_r.ctrl[`PFX_B_CLIP] ||
              (frag_in.x >= st_r.cliph[9:0] && frag_in.x <= st_r.cliph[25:16] &&
               frag_in.y >= st_r.clipv[9:0] && frag_in.y <= st_r.clipv[25:16]);
    // colour key on the pre-combine texture colour
    key_hit = st_r.ctrl[`PFX_B_KEY] && (frag_in.tex_rgb == st_r.key);
    // stipple: row by y, column 7-x
    stip_row = st_r.stip[{frag_in.y[1:0], 3'h0} +: 8];
    stip_bit = stip_row[3'h7 - frag_in.x[2:0]];
    if (!st_r.ctrl[`PFX_B_STIP] || !frag_in.from_tri) stip_ok = 1'b1;
    else if (st_r.ctrl[`PFX_B_PATT]) stip_ok = stip_bit;
    else stip_ok = st_r.stip[31];
    amask_ok = !st_r.ctrl[`PFX_B_AMASK] || frag_in.alpha[0];
    // alpha planes take the aux buffer, so depth test stays off then
    depth_ok = !st_r.ctrl[`PFX_B_DEPTH] || st_r.ctrl[`PFX_B_APLANE] || depth_pass;
    alive = frag_in.valid && clip_ok && stip_ok && amask_ok && depth_ok;
    dv = dith_val(st_r.ctrl[`PFX_B_DITH2], frag_in.x, frag_in.y);
    ry = st_r.ctrl[`PFX_B_YFLIP] && frag_in.from_tri ? `PFX_YMAX - frag_in.y : frag_in.y;

    // pixel output stage, one cycle of latency
    st_nxt.wr_valid = frag_in.valid;
    st_nxt.wr.x = frag_in.x;
    st_nxt.wr.y = ry;
    st_nxt.wr.back_buf = st_r.ctrl[`PFX_B_BUF_LO];
    st_nxt.wr.aux_is_alpha = st_r.ctrl[`PFX_B_APLANE];
    st_nxt.wr.rgb_we = alive && !key_hit && st_r.ctrl[`PFX_B_RGBWR];
    st_nxt.wr.aux_we = alive && st_r.ctrl[`PFX_B_AUXWR];
    st_nxt.wr.depth = st_r.ctrl[`PFX_B_APLANE] ? {8'h00, frag_in.alpha} : depth_store;
    // channels reduced first, then packed into 565
    red_d = chan_red(frag_in.rgb[23:16], dv, st_r.ctrl[`PFX_B_DITH], 1'b0);
    grn_d = chan_red(frag_in.rgb[15:8],  dv, st_r.ctrl[`PFX_B_DITH], 1'b1);
    blu_d = chan_red(frag_in.rgb[7:0],   dv, st_r.ctrl[`PFX_B_DITH], 1'b0);
    st_nxt.wr.rgb565 = {red_d[7:3], grn_d[7:2], blu_d[7:3]};
    st_nxt.wr.dst_dsub = st_r.ctrl[`PFX_B_DSUB] ? dsub565(frag_in.dst_rgb, dv) : frag_in.dst_rgb;
    st_nxt.wr.fail_inc = frag_in.valid && !amask_ok;

    // stipple rotation in rotate mode, whatever bit 2 says
    if (frag_in.valid && frag_in.from_tri && !st_r.ctrl[`PFX_B_PATT])
      st_nxt.stip = {st_r.stip[30:0], st_r.stip[31]};

    // fail counter, hardware increment
    if (frag_in.valid && !amask_ok)
      st_nxt.failcnt = 32'(st_r.failcnt + 32'h1);

    // apb: access phase completes in one cycle
    st_nxt.pready = 1'b0;
    st_nxt.pslverr = 1'b0;
    if (psel && !penable) begin
      st_nxt.pready = 1'b1;
    end
    if (apb_acc && st_r.pready) begin
      st_nxt.pready = 1'b0;
    end
    st_nxt.prdata = `PFX_ZERO32;
    if (psel && !penable) begin
      unique case (paddr)
        `PFX_A_CTRL:    st_nxt.prdata = {11'h000, st_r.ctrl};
        `PFX_A_ZACOL:   st_nxt.prdata = st_r.zacol;
        `PFX_A_CLIPH:   st_nxt.prdata = st_r.cliph;
        `PFX_A_CLIPV:   st_nxt.prdata = st_r.clipv;
        `PFX_A_KEY:     st_nxt.prdata = {8'h00, st_r.key};
        `PFX_A_STIP:    st_nxt.prdata = st_r.stip;
        `PFX_A_FAILCNT: st_nxt.prdata = st_r.failcnt;
        `PFX_A_STAT:    st_nxt.prdata = {30'h00000000, st_r.wr.aux_we, st_r.wr.rgb_we};
        default:        st_nxt.pslverr = 1'b1;
      endcase
    end
    if (apb_acc && st_r.pready && pwrite) begin
      unique case (paddr)
        `PFX_A_CTRL:    st_nxt.ctrl = pwdata[`PFX_CTRL_W-1:0];
        `PFX_A_ZACOL:   st_nxt.zacol = pwdata;
        `PFX_A_CLIPH:   st_nxt.cliph = pwdata;
        `PFX_A_CLIPV:   st_nxt.clipv = pwdata;
        `PFX_A_KEY:     st_nxt.key = pwdata[23:0];
        `PFX_A_STIP:    st_nxt.stip = pwdata;
        `PFX_A_FAILCNT: st_nxt.failcnt = pwdata;
        default:        st_nxt.ctrl = st_r.ctrl;
      endcase
    end
    if (apb_acc && st_r.pready) begin
      st_nxt.pslverr = st_r.pslverr;
      st_nxt.prdata = st_r.prdata;
    end
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flops
  assign prdata   = st_r.prdata;
  assign pready   = st_r.pready;
  assign pslverr  = st_r.pslverr;
  assign wr_out   = st_r.wr;
  assign wr_valid = st_r.wr_valid;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  sequence frag_masked_s;
    frag_in.valid && st_r.ctrl[`PFX_B_AMASK] && !frag_in.alpha[0];
  endsequence
  sequence no_write_s;
    !wr_out.rgb_we && !wr_out.aux_we && wr_out.fail_inc;
  endsequence

  alpha_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    frag_masked_s |=> no_write_s) else $error("alpha masked pixel was written");
  clip_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
    frag_in.valid && st_r.ctrl[`PFX_B_CLIP] && frag_in.x > st_r.cliph[25:16] |=> !wr_out.rgb_we && !wr_out.aux_we)
    else $error("pixel outside clip written");
  color_key_a: assert property (@(posedge pclk) disable iff (!presetn)
    frag_in.valid && st_r.ctrl[`PFX_B_KEY] && frag_in.tex_rgb == st_r.key |=> !wr_out.rgb_we)
    else $error("keyed colour reached rgb buffer");
  stip_rotate_a: assert property (@(posedge pclk) disable iff (!presetn)
    frag_in.valid && frag_in.from_tri && !st_r.ctrl[`PFX_B_PATT] && !(psel && penable && pwrite)
    |=> st_r.stip == {$past(st_r.stip[30:0]), $past(st_r.stip[31])}) else $error("stipple did not rotate");
  stip_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.ctrl[`PFX_B_PATT] && !(psel && penable) |=> $stable(st_r.stip)) else $error("pattern stipple rotated");
  rgb_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    !st_r.ctrl[`PFX_B_RGBWR] |=> !wr_out.rgb_we) else $error("rgb written while masked");
  aux_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    !st_r.ctrl[`PFX_B_AUXWR] |=> !wr_out.aux_we) else $error("depth written while masked");
  never_func_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.ctrl[`PFX_B_DEPTH] && !st_r.ctrl[`PFX_B_APLANE] &&
    st_r.ctrl[`PFX_B_FUNC_HI:`PFX_B_FUNC_LO] == PFX_NEVER |=> !wr_out.aux_we)
    else $error("never function let depth through");
  apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready ##1 !pready) else $error("apb ready not one cycle");

  // --------------------------------------------------------------------------
  // pixel path checks
  // --------------------------------------------------------------------------
  // a pixel that leaves the pipe with neither buffer written, and a stippled one
  sequence dropped_s;
    !wr_out.rgb_we && !wr_out.aux_we;
  endsequence
  sequence tri_stip_s;
    frag_in.valid && frag_in.from_tri && st_r.ctrl[`PFX_B_STIP];
  endsequence

  clip_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    frag_in.valid && st_r.ctrl[`PFX_B_CLIP] && frag_in.y < st_r.clipv[9:0] |=> dropped_s)
    else $error("pixel above clip top written");
  rot_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    tri_stip_s ##0 (!st_r.ctrl[`PFX_B_PATT] && !st_r.stip[31]) |=> dropped_s)
    else $error("rotate stipple zero let pixel through");
  patt_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    tri_stip_s ##0 (st_r.ctrl[`PFX_B_PATT] && !st_r.stip[{frag_in.y[1:0], ~frag_in.x[2:0]}]) |=> dropped_s)
    else $error("pattern stipple zero let pixel through");
  depth_fail_a: assert property (@(posedge pclk) disable iff (!presetn)
    frag_in.valid && st_r.ctrl[`PFX_B_DEPTH] && !st_r.ctrl[`PFX_B_APLANE] && !depth_pass |=> dropped_s)
    else $error("failed depth test let pixel through");
  fail_count_a: assert property (@(posedge pclk) disable iff (!presetn)
    frag_masked_s ##0 (!(psel && penable && pwrite)) |=> st_r.failcnt == 32'($past(st_r.failcnt) + 32'h1))
    else $error("masked pixel not counted");
  buf_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    frag_in.valid |=> wr_valid && wr_out.back_buf == $past(st_r.ctrl[`PFX_B_BUF_LO]))
    else $error("wrong draw buffer");
  y_flip_a: assert property (@(posedge pclk) disable iff (!presetn)
    frag_in.valid && st_r.ctrl[`PFX_B_YFLIP] && frag_in.from_tri
    |=> wr_out.y == 10'(`PFX_YMAX - $past(frag_in.y))) else $error("y origin not flipped");
  y_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    frag_in.valid && !frag_in.from_tri |=> wr_out.y == $past(frag_in.y))
    else $error("y flipped for bypass pixel");
  truncate_a: assert property (@(posedge pclk) disable iff (!presetn)
    frag_in.valid && !st_r.ctrl[`PFX_B_DITH]
    |=> wr_out.rgb565 == {$past(frag_in.rgb[23:19]), $past(frag_in.rgb[15:10]), $past(frag_in.rgb[7:3])})
    else $error("undithered colour not truncated");
  alpha_plane_a: assert property (@(posedge pclk) disable iff (!presetn)
    frag_in.valid && st_r.ctrl[`PFX_B_APLANE]
    |=> wr_out.aux_is_alpha && wr_out.depth == {8'h00, $past(frag_in.alpha)})
    else $error("alpha plane not written with alpha");
  dsub_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    frag_in.valid && !st_r.ctrl[`PFX_B_DSUB] |=> wr_out.dst_dsub == $past(frag_in.dst_rgb))
    else $error("destination colour changed without subtraction");
  depth_store_a: assert property (@(posedge pclk) disable iff (!presetn)
    frag_in.valid && !st_r.ctrl[`PFX_B_APLANE] && !st_r.ctrl[`PFX_B_BIAS]
    |=> wr_out.depth == ($past(st_r.ctrl[`PFX_B_WSEL]) ? $past(frag_in.w_inv) : $past(frag_in.z_iter)))
    else $error("stored depth is not the iterated depth");

  // --------------------------------------------------------------------------
  // bus checks
  // --------------------------------------------------------------------------
  // a control write is a setup cycle followed by the ready access cycle
  sequence ctrl_wr_setup_s;
    psel && !penable && pwrite && paddr == `PFX_A_CTRL;
  endsequence
  sequence access_done_s;
    psel && penable && pready;
  endsequence

  ctrl_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_wr_setup_s ##1 access_done_s |=> st_r.ctrl == $past(pwdata[`PFX_CTRL_W-1:0]))
    else $error("control write did not land");
  stip_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pready && pwrite && paddr == `PFX_A_STIP |=> st_r.stip == $past(pwdata))
    else $error("stipple write lost to rotation");
  ctrl_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pready && !pwrite && paddr == `PFX_A_CTRL |-> prdata == {{(32-`PFX_CTRL_W){1'b0}}, st_r.ctrl})
    else $error("control read returned wrong data");
endmodule

// ===== logic/pfx_params.svh
/*
 * holds the register offsets, field positions, reset values and constants of the pixel fragment stage.
 * assumes inclusion by bare name from the logic files and the testbench.
 */
`ifndef PFX_PARAMS_SVH
`define PFX_PARAMS_SVH
// ----------------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------------
`define PFX_A_CTRL      12'h000
`define PFX_A_ZACOL     12'h004
`define PFX_A_CLIPH     12'h008
`define PFX_A_CLIPV     12'h00c
`define PFX_A_KEY       12'h010
`define PFX_A_STIP      12'h014
`define PFX_A_FAILCNT   12'h018
`define PFX_A_STAT      12'h01c
// ----------------------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------------------
`define PFX_B_CLIP      0
`define PFX_B_KEY       1
`define PFX_B_STIP      2
`define PFX_B_WSEL      3
`define PFX_B_DEPTH     4
`define PFX_B_FUNC_LO   5
`define PFX_B_FUNC_HI   7
`define PFX_B_DITH      8
`define PFX_B_RGBWR     9
`define PFX_B_AUXWR     10
`define PFX_B_DITH2     11
`define PFX_B_PATT      12
`define PFX_B_AMASK     13
`define PFX_B_BUF_LO    14
`define PFX_B_BUF_HI    15
`define PFX_B_BIAS      16
`define PFX_B_YFLIP     17
`define PFX_B_APLANE    18
`define PFX_B_DSUB      19
`define PFX_B_CONSTZ    20
`define PFX_CTRL_W      21
// ----------------------------------------------------------------------------
// reset values and misc
// ----------------------------------------------------------------------------
`define PFX_CTRL_RST    21'h000000
`define PFX_STIP_RST    32'h00000000
`define PFX_ZERO32      32'h00000000
`define PFX_YMAX        10'h3ff
`endif

// ===== logic/pfx_pkg.sv
/*
 * holds the types shared by the pixel fragment stage files.
 * assumes pfx_params.svh is compiled alongside.
 */
package pfx_pkg;
  // depth compare function codes
  typedef enum logic [2:0] {
    PFX_NEVER = 3'h0, PFX_LT = 3'h1, PFX_EQ = 3'h2, PFX_LE = 3'h3,
    PFX_GT    = 3'h4, PFX_NE = 3'h5, PFX_GE = 3'h6, PFX_ALWAYS = 3'h7
  } pfx_func_t;
  // incoming fragment
  typedef struct packed {
    logic        valid;
    logic        from_tri;  // triangle/fill or pipelined linear write
    logic [9:0]  x;
    logic [9:0]  y;
    logic [23:0] rgb;       // post-combine colour
    logic [23:0] tex_rgb;   // colour straight after texture lookup
    logic [7:0]  alpha;
    logic [15:0] z_iter;
    logic [15:0] w_inv;     // 4-bit exponent, 12-bit mantissa
    logic [15:0] dst_depth;
    logic [15:0] dst_rgb;
  } pfx_frag_t;
  // outgoing write toward memory
  typedef struct packed {
    logic        rgb_we;
    logic        aux_we;
    logic        aux_is_alpha;
    logic        back_buf;
    logic [9:0]  x;
    logic [9:0]  y;
    logic [15:0] rgb565;
    logic [15:0] depth;
    logic [15:0] dst_dsub;  // destination colour minus dither, for blending
    logic        fail_inc;
  } pfx_wr_t;
endpackage

// ===== logic/pfx_depth_cmp.sv
/*
 * holds the depth source select, bias and compare of the fragment stage.
 * assumes purely combinational use inside pfx_fragment_ctl.
 */
`timescale 1ns/1ps
`include "pfx_params.svh"
module pfx_depth_cmp import pfx_pkg::*; (
  // control
  input  wire logic        w_sel,
  input  wire logic        bias_en,
  input  wire logic        const_en,
  input  wire pfx_func_t   func,
  input  wire logic [15:0] const_depth,
  // depths
  input  wire logic [15:0] z_iter,
  input  wire logic [15:0] w_inv,
  input  wire logic [15:0] dst_depth,
  // results
  output logic             pass,
  output logic [15:0]      store_depth
);
  logic [15:0] src;
  logic [15:0] cmp_src;
  // iterated depth, biased when asked; what gets stored unless alpha planes are on
  always_comb begin
    src = w_sel ? w_inv : z_iter;
    store_depth = bias_en ? 16'(src + const_depth) : src;
    cmp_src = const_en ? const_depth : store_depth;
  end
  // compare function decode
  always_comb begin
    unique case (func)
      PFX_NEVER:  pass = 1'b0;
      PFX_LT:     pass = cmp_src <  dst_depth;
      PFX_EQ:     pass = cmp_src == dst_depth;
      PFX_LE:     pass = cmp_src <= dst_depth;
      PFX_GT:     pass = cmp_src >  dst_depth;
      PFX_NE:     pass = cmp_src != dst_depth;
      PFX_GE:     pass = cmp_src >= dst_depth;
      PFX_ALWAYS: pass = 1'b1;
    endcase
  end
endmodule

// ===== tb/tb.sv
/*
 * self-checking testbench of the pixel fragment stage: apb setup, corner cases, random pixels.
 * assumes pfx_pkg and pfx_params.svh compiled first; the design answers apb after one setup cycle.
 */
`timescale 1ns/1ps
`include "pfx_params.svh"
module tb import pfx_pkg::*; ;
  // ----------------------------------------------------------------------------
  // signals and bench model state
  // ----------------------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, wr_valid, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, ctrl, zac, clh, clv, key, stip;
  logic [15:0] st;
  pfx_frag_t   frag, f;
  pfx_wr_t     wr_out;
  int          miscompares, comparisons;

  pfx_fragment_ctl i_pfx_fragment_ctl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frag_in(frag), .wr_out(wr_out), .wr_valid(wr_valid)
  );

  // clock of 5 ns
  always #2.5 pclk = ~pclk;

  // ----------------------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------------------
  task automatic end_of_test();
    if (miscompares == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // ----------------------------------------------------------------------------
  // apb master: setup, access held until pready, release after that edge
  // ----------------------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
    chk(err, 32'h0);
  endtask

  task automatic cfg(input logic [31:0] c);
    ctrl = c;
    apb(1'b1, `PFX_A_CTRL, c);
  endtask

  // ----------------------------------------------------------------------------
  // expected write enables {rgb, aux}; st gets the stored depth
  // ----------------------------------------------------------------------------
  function automatic logic [1:0] model(input pfx_frag_t p);
    logic [15:0] src, dd;
    logic pass, sb, ok;
    st  = (ctrl[3] ? p.w_inv : p.z_iter) + (ctrl[16] ? zac[15:0] : 16'h0);
    src = ctrl[20] ? zac[15:0] : st;
    dd  = p.dst_depth;
    case (ctrl[7:5])
      3'h0: pass = 1'b0;
      3'h1: pass = src < dd;
      3'h2: pass = src == dd;
      3'h3: pass = src <= dd;
      3'h4: pass = src > dd;
      3'h5: pass = src != dd;
      3'h6: pass = src >= dd;
      default: pass = 1'b1;
    endcase
    sb = ctrl[12] ? stip[{p.y[1:0], ~p.x[2:0]}] : stip[31];
    ok = !(ctrl[0] && (p.x < clh[9:0] || p.x > clh[25:16] || p.y < clv[9:0] || p.y > clv[25:16]))
      && !(ctrl[2] && p.from_tri && !sb) && !(ctrl[4] && !ctrl[18] && !pass)
      && !(ctrl[13] && !p.alpha[0]);
    return {ok && ctrl[9] && !(ctrl[1] && p.tex_rgb == key[23:0]), ok && ctrl[10]};
  endfunction

  // dithering may lift each truncated channel by one step at most
  function automatic logic dith_ok(input logic [23:0] c, input logic [15:0] q);
    int dr, dg, db;
    dr = int'(q[15:11]) - int'(c[23:19]);
    dg = int'(q[10:5]) - int'(c[15:10]);
    db = int'(q[4:0]) - int'(c[7:3]);
    return dr >= 0 && dr <= 1 && dg >= 0 && dg <= 1 && db >= 0 && db <= 1;
  endfunction

  // destination colour with one step taken off each field, floored at zero
  function automatic logic [15:0] dsub1(input logic [15:0] d);
    return {((d[15:11] == 5'h00) ? 5'h00 : 5'(d[15:11] - 5'h01)), ((d[10:5] == 6'h00) ? 6'h00 : 6'(d[10:5] - 6'h01)),
            ((d[4:0] == 5'h00) ? 5'h00 : 5'(d[4:0] - 5'h01))};
  endfunction

  // one pixel in, its write checked one cycle later
  task automatic pix(input pfx_frag_t p);
    logic [1:0] e;
    e = model(p);
    @(posedge pclk) frag <= p;
    @(posedge pclk) frag.valid <= 1'b0;
    #1;
    chk(wr_valid, 32'h1);
    chk(wr_out.rgb_we, e[1]);
    chk(wr_out.aux_we, e[0]);
    chk(wr_out.back_buf, ctrl[14]);
    chk(wr_out.aux_is_alpha, ctrl[18]);
    chk(wr_out.x, p.x);
    chk(wr_out.y, (ctrl[17] && p.from_tri) ? 10'h3ff - p.y : p.y);
    chk(wr_out.fail_inc, ctrl[13] && !p.alpha[0]);
    chk(wr_out.dst_dsub == p.dst_rgb || (ctrl[19] && wr_out.dst_dsub == dsub1(p.dst_rgb)), 32'h1);
    if (e[1] && !ctrl[8])
      chk(wr_out.rgb565, {p.rgb[23:19], p.rgb[15:10], p.rgb[7:3]});
    else if (e[1])
      chk(dith_ok(p.rgb, wr_out.rgb565), 32'h1);
    if (e[0] && !ctrl[18])
      chk(wr_out.depth, st);
    else if (e[0])
      chk(wr_out.depth, {8'h00, p.alpha});
    if (!ctrl[12] && p.from_tri)
      stip = {stip[30:0], stip[31]};
  endtask

  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h0; pwdata = 32'h0; frag = '0;
    miscompares = 0; comparisons = 0;
    ctrl = 32'h0; zac = 32'h0; clh = 32'h0; clv = 32'h0; key = 32'h0; stip = 32'h0;
    void'($urandom(6));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and an unmapped place
    rdc(`PFX_A_CTRL, 32'h0);
    rdc(`PFX_A_STIP, 32'h0);
    rdc(`PFX_A_FAILCNT, 32'h0);
    rdc(`PFX_A_STAT, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk(err, 32'h1);
    chk(rd, 32'h0);
    // alpha mask fails the pixel and bumps the counter
    cfg(32'h0000_2600);
    f = '0; f.valid = 1'b1; f.from_tri = 1'b1; f.x = 10'h5; f.y = 10'h5;
    pix(f);
    chk(wr_out.fail_inc, 32'h1);
    rdc(`PFX_A_FAILCNT, 32'h1);
    // y flip for pipeline pixels only, back buffer, alpha planes with depth test off
    cfg(32'h0006_4600);
    f.alpha = 8'h1; f.y = 10'h3; f.dst_depth = 16'h0; f.z_iter = 16'h1;
    pix(f);
    f.from_tri = 1'b0;
    pix(f);
    // back-to-back rotation with masking off, then pattern mode never rotates
    stip = 32'h8000_0001;
    apb(1'b1, `PFX_A_STIP, stip);
    cfg(32'h0000_0600);
    f.from_tri = 1'b1;
    @(posedge pclk) frag <= f;
    repeat (3) @(posedge pclk);
    frag.valid <= 1'b0;
    rdc(`PFX_A_STIP, 32'h0000_000c);
    cfg(32'h0000_1600);
    stip = 32'h0000_000c;
    pix(f);
    rdc(`PFX_A_STIP, 32'h0000_000c);
    // random configurations and pixels
    for (int i = 0; i < 320; i++) begin
      if (i % 16 == 0) begin
        zac = $urandom & 32'hffff_000f;
        clh = {6'h0, 10'($urandom_range(512, 1023)), 6'h0, 10'($urandom_range(0, 511))};
        clv = {6'h0, 10'($urandom_range(512, 1023)), 6'h0, 10'($urandom_range(0, 511))};
        key = $urandom & 32'h00ff_ffff;
        stip = $urandom;
        apb(1'b1, `PFX_A_ZACOL, zac);
        apb(1'b1, `PFX_A_CLIPH, clh);
        apb(1'b1, `PFX_A_CLIPV, clv);
        apb(1'b1, `PFX_A_KEY, key);
        apb(1'b1, `PFX_A_STIP, stip);
        cfg($urandom & 32'h0019_7fff);
        rdc(`PFX_A_CTRL, ctrl);
      end
      f = '0; f.valid = 1'b1; f.from_tri = 1'b1;
      f.x = 10'($urandom); f.y = 10'($urandom); f.rgb = 24'($urandom);
      f.tex_rgb = $urandom_range(0, 1) ? key[23:0] : 24'($urandom);
      f.alpha = 8'($urandom); f.dst_rgb = 16'($urandom);
      f.z_iter = 16'($urandom_range(0, 15)); f.w_inv = 16'($urandom_range(0, 15));
      f.dst_depth = 16'($urandom_range(0, 31));
      pix(f);
    end
    rdc(`PFX_A_STIP, stip);
    end_of_test();
  end
endmodule
